// ### design/bcs_cfg.svh
// Constants for the bridge command and status register bank.
// Assumes a plain register port with read data one cycle after the strobe.
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH

`define BCS_ADDR_W        12
`define BCS_OFF_CSR       12'h004
`define BCS_OFF_IRQ_STAT  12'h200
`define BCS_OFF_IRQ_CLR   12'h204
`define BCS_OFF_IRQ_EN    12'h208

`define BCS_BIT_DPE       31
`define BCS_BIT_SSERR     30
`define BCS_BIT_RUR       29
`define BCS_BIT_RCA       28
`define BCS_BIT_SCA       27
`define BCS_BIT_MPE       24
`define BCS_BIT_CAPL      20
`define BCS_BIT_SYS_ERR_EN 8
`define BCS_BIT_PAR_RESP  6

`define BCS_CSR_RESET     32'h0010_0000
`define BCS_CMD_WMASK     16'h0157
`define BCS_NUM_EVT       6

`endif

// ### design/bcs_pkg.sv
// Types for the bridge command and status register bank.
// Assumes the cfg header is included by the design file.
package bcs_pkg;

  // Error flags, one per error bit of the status word; eight event sources feed six flags
  typedef struct packed {
    logic detected_poison_flag;
    logic signaled_system_error_flag;
    logic received_unsupported_flag;
    logic received_abort_flag;
    logic signaled_abort_flag;
    logic master_parity_error_flag;
  } bcs_flags_s;

  // Event pulses from the link logic
  typedef struct packed {
    logic poison_rx;
    logic bad_ecrc_rx;
    logic err_msg_tx;
    logic ur_cpl_rx;
    logic ca_cpl_rx;
    logic ca_cpl_tx;
    logic poison_cpl_rx;
    logic poison_wr_tx;
  } bcs_evt_s;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bcs_req_s;

  // Whole state of the bank
  typedef struct packed {
    logic [15:0] command;
    bcs_flags_s  flags;
    bcs_flags_s  irq_stat;
    bcs_flags_s  irq_en;
    logic [31:0] rdata;
    logic        irq;
    logic        sys_err_en;
    logic        par_resp_en;
  } bcs_state_s;

endpackage

// ### design/bcs_regs.sv
// Command and status register bank of the bridge, with error flags and interrupt.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk_i.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "bcs_cfg.svh"

module bcs_regs (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire bcs_pkg::bcs_req_s req_i,
  input  wire bcs_pkg::bcs_evt_s evt_i,
  output logic [31:0]            rdata_o,
  output logic                   irq_o,
  output logic                   sys_err_en_o,
  output logic                   par_resp_en_o
);

  // Packs flags into their status-word positions
  function automatic logic [31:0] csr_word(input bcs_pkg::bcs_flags_s f, input logic [15:0] cmd);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BCS_BIT_DPE]   = f.detected_poison_flag;
    w[`BCS_BIT_SSERR] = f.signaled_system_error_flag;
    w[`BCS_BIT_RUR]   = f.received_unsupported_flag;
    w[`BCS_BIT_RCA]   = f.received_abort_flag;
    w[`BCS_BIT_SCA]   = f.signaled_abort_flag;
    w[`BCS_BIT_MPE]   = f.master_parity_error_flag;
    w[`BCS_BIT_CAPL]  = 1'b1;
    w[15:0]           = cmd;   // bits 26:25,23,22,21,19,18:11 stay zero
    return w;
  endfunction

  // Extracts flag positions from a written word
  function automatic bcs_pkg::bcs_flags_s word_flags(input logic [31:0] w);
    bcs_pkg::bcs_flags_s f;
    f.detected_poison_flag       = w[`BCS_BIT_DPE];
    f.signaled_system_error_flag = w[`BCS_BIT_SSERR];
    f.received_unsupported_flag  = w[`BCS_BIT_RUR];
    f.received_abort_flag        = w[`BCS_BIT_RCA];
    f.signaled_abort_flag        = w[`BCS_BIT_SCA];
    f.master_parity_error_flag   = w[`BCS_BIT_MPE];
    return f;
  endfunction

  // Flags as a low-aligned vector for the interrupt registers
  function automatic logic [31:0] low_word(input bcs_pkg::bcs_flags_s f);
    return {26'h000_0000, f};
  endfunction

  bcs_pkg::bcs_state_s state_q;
  bcs_pkg::bcs_state_s state_d;
  bcs_pkg::bcs_flags_s set_v;
  bcs_pkg::bcs_flags_s clr_csr_v;
  bcs_pkg::bcs_flags_s clr_irq_v;
  logic                wr_csr;
  logic                wr_iclr;
  logic                wr_ien;

  // Address decode of writes
  assign wr_csr  = req_i.wr && (req_i.addr == `BCS_OFF_CSR);
  assign wr_iclr = req_i.wr && (req_i.addr == `BCS_OFF_IRQ_CLR);
  assign wr_ien  = req_i.wr && (req_i.addr == `BCS_OFF_IRQ_EN);

  // Event qualification per flag
  always_comb begin
    set_v.detected_poison_flag       = evt_i.poison_rx | evt_i.bad_ecrc_rx;
    set_v.signaled_system_error_flag = evt_i.err_msg_tx & state_q.command[`BCS_BIT_SYS_ERR_EN];
    set_v.received_unsupported_flag  = evt_i.ur_cpl_rx;
    set_v.received_abort_flag        = evt_i.ca_cpl_rx;
    set_v.signaled_abort_flag        = evt_i.ca_cpl_tx;
    set_v.master_parity_error_flag   = (evt_i.poison_cpl_rx | evt_i.poison_wr_tx)
                                       & state_q.command[`BCS_BIT_PAR_RESP];
  end

  // Write-one-to-clear masks
  assign clr_csr_v = wr_csr  ? word_flags(req_i.wdata) : '0;
  assign clr_irq_v = wr_iclr ? bcs_pkg::bcs_flags_s'(req_i.wdata[`BCS_NUM_EVT-1:0]) : '0;

  // Next-state computation
  always_comb begin
    state_d = state_q;
    if (wr_csr) begin
      state_d.command = req_i.wdata[15:0] & `BCS_CMD_WMASK;  // constant bits ignored
    end
    state_d.flags    = (state_q.flags & ~clr_csr_v) | set_v;       // set wins
    state_d.irq_stat = (state_q.irq_stat & ~clr_irq_v) | set_v;    // set wins over clear
    if (wr_ien) begin
      state_d.irq_en = bcs_pkg::bcs_flags_s'(req_i.wdata[`BCS_NUM_EVT-1:0]);
    end
    state_d.irq     = |(state_d.irq_stat & state_d.irq_en);
    state_d.sys_err_en  = state_d.command[`BCS_BIT_SYS_ERR_EN];
    state_d.par_resp_en = state_d.command[`BCS_BIT_PAR_RESP];
    state_d.rdata   = 32'h0000_0000;
    if (req_i.rd) begin
      unique case (req_i.addr)
        `BCS_OFF_CSR:      state_d.rdata = csr_word(state_q.flags, state_q.command);
        `BCS_OFF_IRQ_STAT: state_d.rdata = low_word(state_q.irq_stat);
        `BCS_OFF_IRQ_EN:   state_d.rdata = low_word(state_q.irq_en);
        default:           state_d.rdata = 32'h0000_0000;  // Unmapped and write-only read zero
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata_o   = state_q.rdata;
  assign irq_o     = state_q.irq;
  assign sys_err_en_o  = state_q.sys_err_en;
  assign par_resp_en_o = state_q.par_resp_en;

  // Checks: one clock, muted while reset is held
  default clocking chk_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // Read strobe aimed at the command and status word
  sequence s_csr_read;
    req_i.rd && (req_i.addr == `BCS_OFF_CSR);
  endsequence

  // Read strobe aimed at the interrupt status word
  sequence s_stat_read;
    req_i.rd && (req_i.addr == `BCS_OFF_IRQ_STAT);
  endsequence

  // Read strobe aimed at the interrupt enable word
  sequence s_en_read;
    req_i.rd && (req_i.addr == `BCS_OFF_IRQ_EN);
  endsequence

  // Read strobe aimed at an unmapped or write-only address
  sequence s_other_read;
    req_i.rd && (req_i.addr != `BCS_OFF_CSR) && (req_i.addr != `BCS_OFF_IRQ_STAT)
    && (req_i.addr != `BCS_OFF_IRQ_EN);
  endsequence

  // No read strobe in this cycle
  sequence s_idle_bus;
    !req_i.rd;
  endsequence

  // Error message sent while reporting is enabled
  sequence s_err_msg_on;
    evt_i.err_msg_tx && state_q.command[`BCS_BIT_SYS_ERR_EN];
  endsequence

  // Poisoned completion received while parity response is enabled
  sequence s_poison_cpl_on;
    evt_i.poison_cpl_rx && state_q.command[`BCS_BIT_PAR_RESP];
  endsequence

  // Own write poisoned while parity response is enabled
  sequence s_poison_wr_on;
    evt_i.poison_wr_tx && state_q.command[`BCS_BIT_PAR_RESP];
  endsequence

  // Clearing write on the poison flag with no new poison
  sequence s_dpe_clear;
    wr_csr && req_i.wdata[`BCS_BIT_DPE] && !evt_i.poison_rx && !evt_i.bad_ecrc_rx;
  endsequence

  // Clearing write on the unsupported flag with no new event
  sequence s_rur_clear;
    wr_csr && req_i.wdata[`BCS_BIT_RUR] && !evt_i.ur_cpl_rx;
  endsequence

  // Clearing write on the unsupported flag racing a new event
  sequence s_rur_race;
    wr_csr && req_i.wdata[`BCS_BIT_RUR] && evt_i.ur_cpl_rx;
  endsequence

  // Interrupt clear of the unsupported bit with no new event
  sequence s_irq_rur_clear;
    wr_iclr && req_i.wdata[3] && !evt_i.ur_cpl_rx;
  endsequence

  // Either poison source sets the flag
  chk_poison_sets: assert property (
    (evt_i.poison_rx || evt_i.bad_ecrc_rx) |=> state_q.flags.detected_poison_flag)
    else $error("poison flag not set");

  // Bad ECRC alone sets the poison flag
  chk_ecrc_sets: assert property (
    evt_i.bad_ecrc_rx |=> state_q.flags.detected_poison_flag)
    else $error("ecrc did not set poison flag");

  // Poison sets the flag with parity response off
  chk_poison_ungated: assert property (
    (evt_i.poison_rx && !state_q.command[`BCS_BIT_PAR_RESP]) |=> state_q.flags.detected_poison_flag)
    else $error("poison flag gated by parity enable");

  // Enabled error message sets the system error flag
  chk_serr_sets: assert property (
    s_err_msg_on |=> state_q.flags.signaled_system_error_flag)
    else $error("system error flag not set");

  // Disabled error message leaves the flag clear
  chk_serr_gated: assert property (
    (evt_i.err_msg_tx && !state_q.command[`BCS_BIT_SYS_ERR_EN] && !state_q.flags.signaled_system_error_flag)
    |=> !state_q.flags.signaled_system_error_flag)
    else $error("system error flag set while disabled");

  // Unsupported-request completion sets its flag
  chk_ur_sets: assert property (
    evt_i.ur_cpl_rx |=> state_q.flags.received_unsupported_flag)
    else $error("unsupported flag not set");

  // Received completer abort sets its flag
  chk_ca_rx_sets: assert property (
    evt_i.ca_cpl_rx |=> state_q.flags.received_abort_flag)
    else $error("received abort flag not set");

  // Own completer abort sets its flag
  chk_ca_tx_sets: assert property (
    evt_i.ca_cpl_tx |=> state_q.flags.signaled_abort_flag)
    else $error("signaled abort flag not set");

  // Enabled poisoned completion sets the parity flag
  chk_mpe_cpl_sets: assert property (
    s_poison_cpl_on |=> state_q.flags.master_parity_error_flag)
    else $error("parity flag not set by completion");

  // Enabled poisoned write sets the parity flag
  chk_mpe_wr_sets: assert property (
    s_poison_wr_on |=> state_q.flags.master_parity_error_flag)
    else $error("parity flag not set by write");

  // Parity flag never sets with response disabled
  chk_mpe_gated: assert property (
    (!state_q.command[`BCS_BIT_PAR_RESP] && !state_q.flags.master_parity_error_flag)
    |=> !state_q.flags.master_parity_error_flag)
    else $error("parity flag set while disabled");

  // Constant status bits on every status read
  chk_const_bits: assert property (
    s_csr_read |=> rdata_o[`BCS_BIT_CAPL] && rdata_o[26:25] == 2'h0 && rdata_o[23:21] == 3'h0
    && rdata_o[19:11] == 9'h000)
    else $error("constant status bits wrong");

  // Legacy timing and capability bits read zero
  chk_legacy_zero: assert property (
    s_csr_read |=> rdata_o[26:25] == 2'h0 && !rdata_o[23] && !rdata_o[21])
    else $error("legacy bits not zero");

  // Capability-list bit reads one
  chk_capl_one: assert property (
    s_csr_read |=> rdata_o[`BCS_BIT_CAPL])
    else $error("capability bit not one");

  // Interrupt-status bit reads zero
  chk_int_stat_zero: assert property (
    s_csr_read |=> !rdata_o[19])
    else $error("interrupt status bit not zero");

  // Reserved status bits read zero
  chk_reserved_zero: assert property (
    s_csr_read |=> !rdata_o[22] && rdata_o[18:11] == 8'h00)
    else $error("reserved bits not zero");

  // Reporting enable output follows the written bit
  chk_sys_err_out: assert property (
    wr_csr |=> sys_err_en_o == $past(req_i.wdata[`BCS_BIT_SYS_ERR_EN]))
    else $error("reporting enable output wrong");

  // Parity response output follows the written bit
  chk_par_resp_out: assert property (
    wr_csr |=> par_resp_en_o == $past(req_i.wdata[`BCS_BIT_PAR_RESP]))
    else $error("parity response output wrong");

  // Write one clears the unsupported flag
  chk_w1c_clear: assert property (
    s_rur_clear |=> !state_q.flags.received_unsupported_flag)
    else $error("write one did not clear");

  // Write one clears the poison flag
  chk_dpe_clear: assert property (
    s_dpe_clear |=> !state_q.flags.detected_poison_flag)
    else $error("poison flag not cleared");

  // Event in the clearing cycle keeps the flag set
  chk_set_wins: assert property (
    s_rur_race |=> state_q.flags.received_unsupported_flag)
    else $error("clear won over event");

  // Write zero keeps a set flag
  chk_zero_keeps: assert property (
    (wr_csr && !req_i.wdata[`BCS_BIT_RUR] && state_q.flags.received_unsupported_flag)
    |=> state_q.flags.received_unsupported_flag)
    else $error("write zero cleared a flag");

  // Flags hold without events or status writes
  chk_flags_hold: assert property (
    (!wr_csr && evt_i == '0) |=> $stable(state_q.flags))
    else $error("flags changed without cause");

  // Only writable command bits ever read back
  chk_cmd_mask: assert property (
    s_csr_read |=> (rdata_o[15:0] & ~`BCS_CMD_WMASK) == 16'h0000)
    else $error("constant command bit written");

  // Flags and outputs clear on leaving reset
  chk_reset_clear: assert property (
    $past(reset_i) |-> state_q.flags == '0 && rdata_o == 32'h0000_0000 && !irq_o)
    else $error("state not clear after reset");

  // Status read returns the unsupported flag
  chk_flag_readback: assert property (
    s_csr_read |=> rdata_o[`BCS_BIT_RUR] == $past(state_q.flags.received_unsupported_flag))
    else $error("status readback wrong");

  // Read data is zero outside the answer cycle
  chk_read_idle: assert property (
    s_idle_bus |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero when idle");

  // Unmapped and write-only addresses read zero
  chk_unmapped_zero: assert property (
    s_other_read |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Interrupt status reads back low-aligned
  chk_stat_read: assert property (
    s_stat_read |=> rdata_o == {26'h000_0000, $past(state_q.irq_stat)})
    else $error("interrupt status readback wrong");

  // Interrupt enable reads back low-aligned
  chk_en_read: assert property (
    s_en_read |=> rdata_o[5:0] == $past(state_q.irq_en)
    && rdata_o[31:6] == 26'h000_0000)
    else $error("interrupt enable readback wrong");

  // Interrupt is high exactly while an enabled bit is set
  chk_irq_level: assert property (
    irq_o == |(state_q.irq_stat & state_q.irq_en))
    else $error("interrupt level wrong");

  // Interrupt clear drops the unsupported status bit
  chk_irq_rur_clear: assert property (
    s_irq_rur_clear |=> !state_q.irq_stat.received_unsupported_flag)
    else $error("interrupt status not cleared");

  // Interrupt clear leaves the status flag alone
  chk_copies_apart: assert property (
    (wr_iclr && state_q.flags.received_unsupported_flag) |=> state_q.flags.received_unsupported_flag)
    else $error("interrupt clear touched status flag");

endmodule // bcs_regs

// ### sim/bcs_link_model.sv
// Far-side link model: registers requested causes into event pulses of the same length, one cycle later.
// Assumes cause_i is driven just after a rising edge of ref_clk_i.
`timescale 1ns/1ps
module bcs_link_model (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [7:0]   cause_i,
  output bcs_pkg::bcs_evt_s evt_o
);
  // Events leave one edge after the request, as registered link logic would
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      evt_o <= '0;
    end else begin
      evt_o <= bcs_pkg::bcs_evt_s'(cause_i);
    end
  end
endmodule // bcs_link_model

// ### sim/tb.sv
// Self-checking bench for the bridge command and status bank.
// Assumes the design files are compiled first; clock is 20 MHz.
`timescale 1ns/1ps
`include "bcs_cfg.svh"
module tb;
  logic              ref_clk_i       = 1'b0;
  logic              reset_i         = 1'b1;
  bcs_pkg::bcs_req_s req_i           = '0;
  bcs_pkg::bcs_evt_s evt;
  logic [7:0]        cause           = 8'h00;
  logic [31:0]       rdata_o;
  logic [31:0]       d;
  logic              irq_o;
  logic              sys_err_en_o;
  logic              par_resp_en_o;
  int                miscompares     = 0;
  int                samples_checked = 0;
  int                csr_bit [8]     = '{31, 31, 30, 29, 28, 27, 24, 24};
  localparam logic [31:0] BASE = `BCS_CSR_RESET;

  // Clock
  always #25 ref_clk_i = ~ref_clk_i;

  bcs_regs bcs_regs_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .evt_i(evt),
    .rdata_o(rdata_o), .irq_o(irq_o), .sys_err_en_o(sys_err_en_o), .par_resp_en_o(par_resp_en_o));
  bcs_link_model bcs_link_model_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cause_i(cause), .evt_o(evt));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_i.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_i.rd <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic fire(input logic [7:0] c);
    @(posedge ref_clk_i);
    cause <= c;
    @(posedge ref_clk_i);
    cause <= 8'h00;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic t_const;
    rd(`BCS_OFF_CSR, d); chk("csr reset", d, BASE);
    wr(`BCS_OFF_CSR, 32'hffff_ffff);
    rd(`BCS_OFF_CSR, d); chk("csr ones", d, BASE | 32'h157);
    chk("enables", {30'h0000_0000, sys_err_en_o, par_resp_en_o}, 32'h3);
  endtask
  // Every event source sets its flag, write one clears it
  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      fire(8'h80 >> i);
      rd(`BCS_OFF_CSR, d); chk("flag set", d, BASE | 32'h157 | (32'h1 << csr_bit[i]));
      wr(`BCS_OFF_CSR, (32'h1 << csr_bit[i]) | 32'h157);
      rd(`BCS_OFF_CSR, d); chk("flag clear", d, BASE | 32'h157);
    end
  endtask
  task automatic t_gate;
    wr(`BCS_OFF_CSR, 32'h0);
    fire(8'h23);
    rd(`BCS_OFF_CSR, d); chk("gated", d, BASE);
    fire(8'h80);
    rd(`BCS_OFF_CSR, d); chk("poison ungated", d, BASE | 32'h8000_0000);
    wr(`BCS_OFF_CSR, 32'h8000_0000);
  endtask
  // Event and clearing write at the same edge
  task automatic t_race;
    @(posedge ref_clk_i);
    cause <= 8'h10;
    @(posedge ref_clk_i);
    cause <= 8'h00;
    req_i <= '{addr: `BCS_OFF_CSR, wdata: 32'h2000_0000, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_i.wr <= 1'b0;
    rd(`BCS_OFF_CSR, d); chk("set wins", d, BASE | 32'h2000_0000);
    wr(`BCS_OFF_CSR, 32'h2000_0000);
    rd(`BCS_OFF_CSR, d); chk("cleared", d, BASE);
  endtask
  task automatic t_irq;
    wr(`BCS_OFF_IRQ_CLR, 32'h3f);
    wr(`BCS_OFF_IRQ_EN, 32'h08);
    fire(8'h10);
    chk("irq high", irq_o, 32'h1);
    rd(`BCS_OFF_IRQ_STAT, d); chk("irq stat", d, 32'h08);
    wr(`BCS_OFF_IRQ_CLR, 32'h08);
    @(posedge ref_clk_i);
    #1 chk("irq low", irq_o, 32'h0);
    wr(`BCS_OFF_IRQ_EN, 32'h0);
    fire(8'h10);
    chk("irq masked", irq_o, 32'h0);
    rd(`BCS_OFF_IRQ_STAT, d); chk("stat masked", d, 32'h08);
    rd(12'h300, d); chk("unmapped", d, 32'h0);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_const();
    t_events();
    t_gate();
    t_race();
    t_irq();
    end_sim();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    end_sim();
  end
endmodule // tb
